// ### core/afe_config_register_bank.sv
`timescale 1ns/100ps
// apb slave holding the front-end configuration words
module afe_config_register_bank
    import afe_cfg_pkg::*;
(
    // apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // receive amplifier switches
    output logic [ELEC_N-1:0] pos_electrode_switch,
    output logic [CAL_N-1:0] pos_calibration_switch,
    output logic [ELEC_N-1:0] neg_electrode_switch,
    output logic [CAL_N-1:0] neg_calibration_switch,
    // measurement mode
    output logic quadrature_mode_sel,
    // weight path
    output logic [GAIN_W-1:0] weight_stage2_gain,
    output logic signed [OFFSET_W-1:0] weight_offset_code,
    // excitation and demodulator clock
    output logic [FREQ_W-1:0] excitation_freq_field,
    output logic [DIV_W-1:0] quadrature_clock_divider
);
    typedef struct packed {
        logic [31:0] rdata;
        logic err;
    } bus_s;
    bus_s st_q;
    bus_s st_d;

    logic [NREG-1:0] hit;
    logic [NREG-1:0] wr;
    logic [15:0] val [NREG];
    logic access;
    localparam logic [15:0] MASKS [NREG] = '{MASK_SWITCHES, MASK_MODE, MASK_WEIGHT,
        MASK_FREQ, MASK_DEMODCLK};

    // address decode
    assign hit[0] = (paddr == OFS_SWITCHES);
    assign hit[1] = (paddr == OFS_MODE);
    assign hit[2] = (paddr == OFS_WEIGHT);
    assign hit[3] = (paddr == OFS_FREQ);
    assign hit[4] = (paddr == OFS_DEMODCLK);
    assign access = psel & penable;
    assign wr = (access & pwrite) ? hit : '0;

    // storage words
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            cfg_word_reg #(.MASK(MASKS[gi])) u_reg (
                .pclk(pclk),
                .presetn(presetn),
                .wr(wr[gi]),
                .wdata(pwdata[15:0]),
                .value(val[gi])
            );
        end
    endgenerate

    // read data prepared in the setup cycle, error for unmapped address
    always_comb begin
        st_d = st_q;
        if (psel && !penable) begin
            st_d.err = ~|hit;
            st_d.rdata = '0;
            for (int i = 0; i < NREG; i++) begin
                if (hit[i]) begin
                    st_d.rdata = {16'h0000, val[i]};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{rdata: 32'h0000_0000, err: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign pready = 1'b1;
    assign prdata = st_q.rdata;
    assign pslverr = access & st_q.err;

    // analog control fields
    assign pos_electrode_switch = val[0][POS_ELEC_LSB +: ELEC_N];
    assign pos_calibration_switch = val[0][POS_CAL_LSB +: CAL_N];
    assign neg_electrode_switch = val[0][NEG_ELEC_LSB +: ELEC_N];
    assign neg_calibration_switch = val[0][NEG_CAL_LSB +: CAL_N];
    assign quadrature_mode_sel = val[1][MODE_BIT];
    assign weight_stage2_gain = val[2][GAIN_LSB +: GAIN_W];
    assign weight_offset_code = $signed(val[2][OFFSET_LSB +: OFFSET_W]);
    assign excitation_freq_field = val[3][FREQ_LSB +: FREQ_W];
    assign quadrature_clock_divider = val[4][DIV_LSB +: DIV_W];

    // checks
    property p_write_switch;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == OFS_SWITCHES) |=>
            {pos_electrode_switch, pos_calibration_switch, neg_electrode_switch,
             neg_calibration_switch} == $past(pwdata[15:0]);
    endproperty
    a_write_switch: assert property (p_write_switch) else $error("switch write lost");
    property p_mode;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == OFS_MODE) |=>
            quadrature_mode_sel == $past(pwdata[MODE_BIT]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode write lost");
    property p_gain;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == OFS_WEIGHT) |=>
            weight_stage2_gain == $past(pwdata[GAIN_LSB +: GAIN_W]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain write lost");
    property p_offset;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == OFS_WEIGHT) |=>
            weight_offset_code == $past(pwdata[OFFSET_LSB +: OFFSET_W]);
    endproperty
    a_offset: assert property (p_offset) else $error("offset write lost");
    property p_freq;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == OFS_FREQ) |=>
            excitation_freq_field == $past(pwdata[FREQ_LSB +: FREQ_W]);
    endproperty
    a_freq: assert property (p_freq) else $error("frequency write lost");
    property p_div;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr == OFS_DEMODCLK) |=>
            quadrature_clock_divider == $past(pwdata[DIV_LSB +: DIV_W]);
    endproperty
    a_div: assert property (p_div) else $error("divider write lost");
    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite) |=> $stable(weight_stage2_gain) && $stable(excitation_freq_field);
    endproperty
    a_hold: assert property (p_hold) else $error("field changed without write");
    property p_readback;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_FREQ) ##1 (access)
            |-> prdata == 32'(excitation_freq_field);
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    // address-map view for the checks, built from the offsets alone
    logic mapped_addr;
    assign mapped_addr = paddr inside {OFS_SWITCHES, OFS_MODE, OFS_WEIGHT, OFS_FREQ,
        OFS_DEMODCLK};

    // reset values, seen at the first edge after reset is released
    // positive electrode switches open
    property p_rst_pe;
        @(posedge pclk) $rose(presetn) |-> pos_electrode_switch == '0;
    endproperty
    a_rst_pe: assert property (p_rst_pe) else $error("pos electrode not open");
    // positive calibration switches open
    property p_rst_pc;
        @(posedge pclk) $rose(presetn) |-> pos_calibration_switch == '0;
    endproperty
    a_rst_pc: assert property (p_rst_pc) else $error("pos calibration not open");
    // negative electrode switches open
    property p_rst_ne;
        @(posedge pclk) $rose(presetn) |-> neg_electrode_switch == '0;
    endproperty
    a_rst_ne: assert property (p_rst_ne) else $error("neg electrode not open");
    // negative calibration switches open
    property p_rst_nc;
        @(posedge pclk) $rose(presetn) |-> neg_calibration_switch == '0;
    endproperty
    a_rst_nc: assert property (p_rst_nc) else $error("neg calibration not open");
    // rectifier measurement selected
    property p_rst_mode;
        @(posedge pclk) $rose(presetn) |-> !quadrature_mode_sel;
    endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("mode not rectifier");
    // second-stage gain of one
    property p_rst_gain;
        @(posedge pclk) $rose(presetn) |-> weight_stage2_gain == '0;
    endproperty
    a_rst_gain: assert property (p_rst_gain) else $error("gain not one");
    // offset correction of zero
    property p_rst_ofs;
        @(posedge pclk) $rose(presetn) |-> weight_offset_code == '0;
    endproperty
    a_rst_ofs: assert property (p_rst_ofs) else $error("offset not zero");
    // excitation frequency word of zero
    property p_rst_freq;
        @(posedge pclk) $rose(presetn) |-> excitation_freq_field == '0;
    endproperty
    a_rst_freq: assert property (p_rst_freq) else $error("frequency not zero");
    // demodulator divider code of zero
    property p_rst_div;
        @(posedge pclk) $rose(presetn) |-> quadrature_clock_divider == '0;
    endproperty
    a_rst_div: assert property (p_rst_div) else $error("divider not zero");
    // bus answer cleared
    property p_rst_bus;
        @(posedge pclk) $rose(presetn) |-> prdata == '0 && !pslverr;
    endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("bus answer not clear");

    // each word only moves on a write to its own address
    // switch word
    property p_hold_sw;
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && paddr == OFS_SWITCHES) |=>
            $stable({pos_electrode_switch, pos_calibration_switch, neg_electrode_switch,
                     neg_calibration_switch});
    endproperty
    a_hold_sw: assert property (p_hold_sw) else $error("switch moved");
    // mode word
    property p_hold_mode;
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && paddr == OFS_MODE) |=>
            $stable(quadrature_mode_sel);
    endproperty
    a_hold_mode: assert property (p_hold_mode) else $error("mode moved");
    // weight word
    property p_hold_weight;
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && paddr == OFS_WEIGHT) |=>
            $stable({weight_stage2_gain, weight_offset_code});
    endproperty
    a_hold_weight: assert property (p_hold_weight) else $error("weight moved");
    // frequency word
    property p_hold_freq;
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && paddr == OFS_FREQ) |=>
            $stable(excitation_freq_field);
    endproperty
    a_hold_freq: assert property (p_hold_freq) else $error("frequency moved");
    // divider word
    property p_hold_div;
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && paddr == OFS_DEMODCLK) |=>
            $stable(quadrature_clock_divider);
    endproperty
    a_hold_div: assert property (p_hold_div) else $error("divider moved");

    // read data in the access phase mirrors the stored fields
    // switch word
    property p_rb_sw;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_SWITCHES) ##1 (access)
            |-> prdata == {16'h0000, pos_electrode_switch, pos_calibration_switch,
                           neg_electrode_switch, neg_calibration_switch};
    endproperty
    a_rb_sw: assert property (p_rb_sw) else $error("switch readback");
    // mode word, unused bits zero
    property p_rb_mode;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_MODE) ##1 (access)
            |-> prdata == (32'(quadrature_mode_sel) << MODE_BIT);
    endproperty
    a_rb_mode: assert property (p_rb_mode) else $error("mode readback");
    // weight word
    property p_rb_weight;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_WEIGHT) ##1 (access)
            |-> prdata[GAIN_LSB +: GAIN_W] == weight_stage2_gain &&
                prdata[OFFSET_LSB +: OFFSET_W] == weight_offset_code;
    endproperty
    a_rb_weight: assert property (p_rb_weight) else $error("weight readback");
    // divider word
    property p_rb_div;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == OFS_DEMODCLK) ##1 (access)
            |-> prdata[DIV_LSB +: DIV_W] == quadrature_clock_divider;
    endproperty
    a_rb_div: assert property (p_rb_div) else $error("divider readback");
    // upper half of every read is zero
    property p_rb_upper;
        @(posedge pclk) disable iff (!presetn)
        (access && !pwrite) |-> prdata[31:16] == 16'h0000;
    endproperty
    a_rb_upper: assert property (p_rb_upper) else $error("upper read bits set");

    // refusal of unmapped addresses
    // error raised in the access phase
    property p_err_flag;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped_addr) ##1 (access) |-> pslverr;
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("unmapped not refused");
    // refused access returns zero
    property p_err_data;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !mapped_addr) ##1 (access) |-> prdata == '0;
    endproperty
    a_err_data: assert property (p_err_data) else $error("unmapped data not zero");
    // mapped addresses never refused
    property p_ok_mapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && mapped_addr) ##1 (access) |-> !pslverr;
    endproperty
    a_ok_mapped: assert property (p_ok_mapped) else $error("mapped refused");
    // error only shown in an access phase
    property p_err_idle;
        @(posedge pclk) disable iff (!presetn)
        !access |-> !pslverr;
    endproperty
    a_err_idle: assert property (p_err_idle) else $error("error outside access");
    // a refused write changes no control output
    property p_err_nowrite;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && !mapped_addr) |=>
            $stable({pos_electrode_switch, pos_calibration_switch, neg_electrode_switch,
                     neg_calibration_switch, quadrature_mode_sel, weight_stage2_gain,
                     weight_offset_code, excitation_freq_field, quadrature_clock_divider});
    endproperty
    a_err_nowrite: assert property (p_err_nowrite) else $error("refused write landed");

    // read data only moves on a setup edge
    property p_rdata_stands;
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable) |=> $stable(prdata);
    endproperty
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
endmodule // afe_config_register_bank

// ### core/afe_cfg_pkg.sv
// Summary of operation
// - Bits 15:10 of the switch register each close a positive-input electrode switch when set.
// - Bits 9:8 of the switch register each connect calibration to the positive input when set.
// - Bits 7:2 of the switch register each close a negative-input electrode switch when set.
// - Bits 1:0 of the switch register each connect calibration to the negative input when set.
// - Mode bit 11 selects rectifier measurement at zero and I/Q demodulation at one.
// - Gain field 14:13 selects second-stage gain 1 to 4 for codes 00 to 11.
// - Offset field 5:0 is a twos-complement value from -32 to 31, reset zero.
// - The offset value is applied at the second stage, 31.2 mV per step at stage one.
// - Frequency field 8:0 sets excitation frequency to field times input clock over 1024.
// - Any frequency code is accepted in rectifier mode; I/Q mode needs compatible codes.
package afe_cfg_pkg;
    localparam int ADDR_W = 12;
    // register indices; the bus sees each word at four times its index
    localparam logic [ADDR_W-1:0] IDX_SWITCHES = 12'h00B;
    localparam logic [ADDR_W-1:0] IDX_MODE = 12'h00C;
    localparam logic [ADDR_W-1:0] IDX_WEIGHT = 12'h00D;
    localparam logic [ADDR_W-1:0] IDX_FREQ = 12'h00E;
    localparam logic [ADDR_W-1:0] IDX_DEMODCLK = 12'h00F;
    localparam logic [ADDR_W-1:0] OFS_SWITCHES = IDX_SWITCHES << 2;
    localparam logic [ADDR_W-1:0] OFS_MODE = IDX_MODE << 2;
    localparam logic [ADDR_W-1:0] OFS_WEIGHT = IDX_WEIGHT << 2;
    localparam logic [ADDR_W-1:0] OFS_FREQ = IDX_FREQ << 2;
    localparam logic [ADDR_W-1:0] OFS_DEMODCLK = IDX_DEMODCLK << 2;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // writable masks, unused bits hold zero
    localparam logic [15:0] MASK_SWITCHES = 16'hFFFF;
    localparam logic [15:0] MASK_MODE = 16'h0800;
    localparam logic [15:0] MASK_WEIGHT = 16'h603F;
    localparam logic [15:0] MASK_FREQ = 16'h01FF;
    localparam logic [15:0] MASK_DEMODCLK = 16'h3800;
    localparam int POS_ELEC_LSB = 10;
    localparam int POS_CAL_LSB = 8;
    localparam int NEG_ELEC_LSB = 2;
    localparam int NEG_CAL_LSB = 0;
    localparam int MODE_BIT = 11;
    localparam int GAIN_LSB = 13;
    localparam int OFFSET_LSB = 0;
    localparam int FREQ_LSB = 0;
    localparam int DIV_LSB = 11;
    localparam int ELEC_N = 6;
    localparam int CAL_N = 2;
    localparam int GAIN_W = 2;
    localparam int OFFSET_W = 6;
    localparam int FREQ_W = 9;
    localparam int DIV_W = 3;
    localparam int NREG = 5;
endpackage

// ### core/cfg_word_reg.sv
`timescale 1ns/100ps
// one 16-bit configuration word with write mask
module cfg_word_reg
    import afe_cfg_pkg::*;
#(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input wire logic wr,
    input wire logic [15:0] wdata,
    // stored value
    output logic [15:0] value
);
    typedef struct packed {
        logic [15:0] word;
    } word_s;
    word_s st_q;
    word_s st_d;

    // next value: masked store on write
    always_comb begin
        st_d = st_q;
        if (wr) begin
            st_d.word = wdata & MASK;
        end
    end

    // register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{word: REG_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.word;
endmodule // cfg_word_reg

// ### dv/afe_config_register_bank_tb.sv
`timescale 1ns/100ps
module afe_config_register_bank_tb import afe_cfg_pkg::*;;
    // apb side driven by the bench
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdv;
    logic pready, pslverr, erv;
    logic [ELEC_N-1:0] pe, ne;
    logic [CAL_N-1:0] pc, nc;
    logic qm;
    logic [GAIN_W-1:0] g;
    logic signed [OFFSET_W-1:0] oc;
    logic [FREQ_W-1:0] fq;
    logic [DIV_W-1:0] dv;
    logic [ADDR_W-1:0] ofs [NREG] = '{OFS_SWITCHES, OFS_MODE, OFS_WEIGHT, OFS_FREQ, OFS_DEMODCLK};
    int error_cnt = 0, comparisons = 0, cyc = 0;

    afe_config_register_bank DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pos_electrode_switch(pe),
        .pos_calibration_switch(pc), .neg_electrode_switch(ne), .neg_calibration_switch(nc),
        .quadrature_mode_sel(qm), .weight_stage2_gain(g), .weight_offset_code(oc),
        .excitation_freq_field(fq), .quadrature_clock_divider(dv));

    // clock and hang guard
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end

    task close_out();
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer: setup, access until pready, then release
    task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task rd(input logic [ADDR_W-1:0] a, input logic [15:0] e, input logic se);
        apb(1'b0, a, 16'h0000);
        chk(rdv, {16'h0000, e});
        chk(erv, se);
    endtask

    // control outputs after reset are all zero
    task t_zero();
        chk({pe, pc, ne, nc}, 32'h0000_0000);
        chk({qm, g, oc, fq, dv}, 32'h0000_0000);
    endtask

    task t_reset();
        t_zero();
        for (int i = 0; i < NREG; i++) rd(ofs[i], 16'h0000, 1'b0);
    endtask

    task t_switches();
        logic [15:0] p [2] = '{16'hA6C9, 16'h5936};
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, OFS_SWITCHES, p[i]);
            chk({pe, pc, ne, nc}, p[i]);
            rd(OFS_SWITCHES, p[i], 1'b0);
        end
    endtask

    // frequency and divider set before entering quadrature mode
    task t_mode();
        apb(1'b1, OFS_FREQ, 16'h01FF);
        chk(fq, 9'h1FF);
        rd(OFS_FREQ, 16'h01FF, 1'b0);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, OFS_DEMODCLK, 16'(c << 11));
            chk(dv, c[2:0]);
        end
        rd(OFS_DEMODCLK, 16'h3800, 1'b0);
        // frequency word paired with the divider for a four-times demodulator clock
        apb(1'b1, OFS_FREQ, 16'h0010);
        chk(fq, 9'h010);
        apb(1'b1, OFS_MODE, 16'h0800);
        chk(qm, 1'b1);
        rd(OFS_MODE, 16'h0800, 1'b0);
        apb(1'b1, OFS_MODE, 16'h0000);
        chk(qm, 1'b0);
    endtask

    task t_weight();
        logic [5:0] o [4] = '{6'h20, 6'h1F, 6'h3F, 6'h01};
        int v [4] = '{-32, 31, -1, 1};
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_WEIGHT, {1'b0, c[1:0], 7'h00, o[c]});
            chk({g, oc}, {c[1:0], o[c]});
            chk(32'(oc), v[c]);
        end
        rd(OFS_WEIGHT, 16'h6001, 1'b0);
    endtask

    // unmapped address is refused and leaves the switches alone
    task t_unmapped();
        apb(1'b1, 12'h040, 16'hFFFF);
        chk(erv, 1'b1);
        rd(12'h040, 16'h0000, 1'b1);
        rd(OFS_SWITCHES, 16'h5936, 1'b0);
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_switches();
        t_mode();
        t_weight();
        t_unmapped();
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        t_zero();
        @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        close_out();
    end
endmodule // afe_config_register_bank_tb
